// ===== rts_pkg.sv
// shared constants and types for the radio test and status register bank
package rts_pkg;
  // ------------------------------------------------------------------
  // register offsets (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_SYNTH_CAL_CONTROL = 8'h26;
  localparam logic [7:0] IDX_RC_OSC_CONFIG_HI = 8'h27;
  localparam logic [7:0] IDX_RC_OSC_CONFIG_LO = 8'h28;
  localparam logic [7:0] IDX_SYNTH_TEST = 8'h29;
  localparam logic [7:0] IDX_PRODUCTION_TEST = 8'h2a;
  localparam logic [7:0] IDX_GAIN_CONTROL_TEST = 8'h2b;
  localparam logic [7:0] IDX_SENSITIVITY_TUNE_A = 8'h2c;
  localparam logic [7:0] IDX_SENSITIVITY_TUNE_B = 8'h2d;
  localparam logic [7:0] IDX_SENSITIVITY_TUNE_C = 8'h2e;
  localparam logic [7:0] IDX_CHIP_PART_ID = 8'h30;
  localparam logic [7:0] IDX_CHIP_REVISION_ID = 8'h31;
  localparam logic [7:0] IDX_FREQ_OFFSET_ESTIMATE = 8'h32;
  localparam logic [7:0] IDX_LINK_QUALITY = 8'h33;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH = 8'h34;
  localparam logic [7:0] IDX_RADIO_STATE_CODE = 8'h35;
  // status alias: base offset with the two top address bits set
  localparam logic [7:0] STATUS_ALIAS_BITS = 8'hc0;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [6:0] RST_SYNTH_CAL_CONTROL = 7'h0d;
  localparam logic [6:0] RST_RC_OSC_CONFIG_HI = 7'h41;
  localparam logic [6:0] RST_RC_OSC_CONFIG_LO = 7'h00;
  localparam logic [7:0] RST_SYNTH_TEST = 8'h59;
  localparam logic [7:0] RST_PRODUCTION_TEST = 8'h7f;
  localparam logic [7:0] RST_GAIN_CONTROL_TEST = 8'h3f;
  localparam logic [7:0] RST_SENSITIVITY_TUNE_A = 8'h88;
  localparam logic [7:0] RST_SENSITIVITY_TUNE_B = 8'h31;
  localparam logic [7:0] RST_SENSITIVITY_TUNE_C = 8'h0b;
  // ------------------------------------------------------------------
  // field positions and special values
  // ------------------------------------------------------------------
  localparam int VCO_SELECT_STAGE_BIT = 1;
  localparam int CRC_MATCH_BIT = 7;
  localparam logic [7:0] TEMP_SENSOR_ENABLE_CODE = 8'hbf;
  localparam int LQI_WINDOW_SYMBOLS = 64;
  // ------------------------------------------------------------------
  // radio state codes
  // ------------------------------------------------------------------
  localparam logic [4:0] STATE_SLEEP = 5'h00;
  localparam logic [4:0] STATE_IDLE = 5'h01;
  localparam logic [4:0] STATE_CRYSTAL_OFF = 5'h02;
  localparam logic [4:0] STATE_MANUAL_CAL_OSC_ON = 5'h03;
  localparam logic [4:0] STATE_MANUAL_CAL_REGULATOR_ON = 5'h04;
  localparam logic [4:0] STATE_MANUAL_CALIBRATION = 5'h05;
  localparam logic [4:0] STATE_WAKEUP_OSC_ON = 5'h06;
  localparam logic [4:0] STATE_WAKEUP_REGULATOR_ON = 5'h07;
  localparam logic [4:0] STATE_CALIBRATION_BEGIN = 5'h08;
  localparam logic [4:0] STATE_SETTLE_BANDWIDTH_BOOST = 5'h09;
  localparam logic [4:0] STATE_SETTLE_SYNTH_LOCK = 5'h0a;
  localparam logic [4:0] STATE_SETTLE_CONVERTER_ON = 5'h0b;
  localparam logic [4:0] STATE_CALIBRATION_FINISH = 5'h0c;
  localparam logic [4:0] STATE_RX = 5'h0d;
  localparam logic [4:0] STATE_RX_END = 5'h0e;
  localparam logic [4:0] STATE_RX_RESTART = 5'h0f;
  localparam logic [4:0] STATE_TX_TO_RX_TURNAROUND = 5'h10;
  localparam logic [4:0] STATE_RECEIVE_BUFFER_OVERRUN = 5'h11;
  localparam logic [4:0] STATE_SYNTH_READY_FOR_TX = 5'h12;
  localparam logic [4:0] STATE_TX = 5'h13;
  localparam logic [4:0] STATE_TX_END = 5'h14;
  localparam logic [4:0] STATE_RX_TO_TX_TURNAROUND = 5'h15;
  localparam logic [4:0] STATE_TRANSMIT_BUFFER_UNDERRUN = 5'h16;
  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // modem side status inputs, grouped
  typedef struct packed {
    logic [7:0] freqOffset;
    logic onOffKeying;
    logic crcDone;
    logic crcMatch;
    logic lqiValid;
    logic [6:0] lqiValue;
    logic rssiValid;
    logic [7:0] rssiValue;
    logic [4:0] radioState;
  } rts_modem_status_t;
endpackage : rts_pkg

// ===== rts_register_bank.sv
// register bank: synthesizer, rc oscillator, test and status registers over axi4-lite
//
// Summary of operation
// - production test holding 0xBF enables temperature sensor while idle.
// - test group from 0x29 reverts to reset values on sleep.
// - frequency offset estimate is 8-bit two's complement, step xtal over 2^14.
// - offset estimate reads zero when on-off keying is selected.
// - link quality bit 7 is crc match, cleared on receive entry or restart.
// - crc match flag meaningful only with legacy compatibility enabled.
// - 7-bit link quality over 64 symbols after sync, higher means easier.
// - read-only 8-bit received signal strength updated by receiver.
// - radio state code in bits 4:0, bits 7:5 read zero.
// - state code values follow the main radio state machine table.
// - two rc oscillator registers, 7 bits, reset 0x41 and 0x00.
// - synthesizer calibration control 7 bits, reset 0x0D, bit 7 zero.
// - sensitivity tune c bit 1 enables vco selection calibration stage.
// - status registers also answer at base offset with top two bits set.
// - part and revision identity registers at consecutive status addresses.
`timescale 1ns/10ps
module rts_register_bank
  import rts_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a,   // arbitrary identity value
  parameter logic [7:0] REVISION_ID = 8'h01 // arbitrary identity value
) (
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // modem side
  input rts_modem_status_t modemStatus,
  input wire logic legacyCompatEnable,
  input wire logic rxEnter,
  // control outputs
  output logic tempSensorEnable,
  output logic vcoSelectStageEnable,
  output logic [6:0] synthCalControl,
  output logic [6:0] rcOscConfigHi,
  output logic [6:0] rcOscConfigLo,
  output logic [7:0] synthTest,
  output logic [7:0] gainControlTest,
  output logic [7:0] sensitivityTuneA,
  output logic [7:0] sensitivityTuneB
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic rstn;

  // async assert, two-flop release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstn = rstSync_q[1];

  // ------------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------------
  // word index of a byte address, alias bits kept
  function automatic logic [7:0] wordIndex(input logic [11:0] addr);
    return addr[9:2];
  endfunction : wordIndex

  // only status registers answer at the alias; config reads there are refused
  function automatic logic [7:0] statusBase(input logic [7:0] idx);
    logic [7:0] base;
    base = idx & ~STATUS_ALIAS_BITS;
    if (((idx & STATUS_ALIAS_BITS) == STATUS_ALIAS_BITS) && (base >= IDX_CHIP_PART_ID)) begin
      return base;
    end
    return idx;
  endfunction : statusBase

  // ------------------------------------------------------------------
  // write channel capture
  // ------------------------------------------------------------------
  logic awHeld_q;
  logic [11:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic doWrite;
  logic [7:0] wrIdx;
  logic wrLane0;

  // both readies drop while a response waits, so writes never overlap
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrIdx = wordIndex(awAddr_q);
  assign wrLane0 = wStrb_q[0];

  // address and data may arrive in either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // write response
  // ------------------------------------------------------------------
  logic [1:0] bResp_q;
  logic wrMapped;

  // only the writable window is mapped for writes; status writes are refused
  assign wrMapped = (wrIdx >= IDX_SYNTH_CAL_CONTROL) && (wrIdx <= IDX_SENSITIVITY_TUNE_C);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  // ------------------------------------------------------------------
  // configuration registers (kept through sleep)
  // ------------------------------------------------------------------
  logic [6:0] synthCal_q;
  logic [6:0] rcHi_q;
  logic [6:0] rcLo_q;
  logic wrLow;

  assign wrLow = doWrite && wrLane0;

  // bit 7 is not stored, so it always reads zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      synthCal_q <= RST_SYNTH_CAL_CONTROL;
      rcHi_q <= RST_RC_OSC_CONFIG_HI;
      rcLo_q <= RST_RC_OSC_CONFIG_LO;
    end else if (wrLow) begin
      if (wrIdx == IDX_SYNTH_CAL_CONTROL) synthCal_q <= wData_q[6:0];
      if (wrIdx == IDX_RC_OSC_CONFIG_HI) rcHi_q <= wData_q[6:0];
      if (wrIdx == IDX_RC_OSC_CONFIG_LO) rcLo_q <= wData_q[6:0];
    end
  end

  // ------------------------------------------------------------------
  // test group (lost in sleep)
  // ------------------------------------------------------------------
  logic [7:0] synthTest_q;
  logic [7:0] prodTest_q;
  logic [7:0] gainTest_q;
  logic [7:0] tuneA_q;
  logic [7:0] tuneB_q;
  logic [7:0] tuneC_q;
  logic inSleep;

  assign inSleep = modemStatus.radioState == STATE_SLEEP;

  // sleep returns the group to defaults; host must reprogram after wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      synthTest_q <= RST_SYNTH_TEST;
      prodTest_q <= RST_PRODUCTION_TEST;
      gainTest_q <= RST_GAIN_CONTROL_TEST;
      tuneA_q <= RST_SENSITIVITY_TUNE_A;
      tuneB_q <= RST_SENSITIVITY_TUNE_B;
      tuneC_q <= RST_SENSITIVITY_TUNE_C;
    end else if (inSleep) begin
      synthTest_q <= RST_SYNTH_TEST;
      prodTest_q <= RST_PRODUCTION_TEST;
      gainTest_q <= RST_GAIN_CONTROL_TEST;
      tuneA_q <= RST_SENSITIVITY_TUNE_A;
      tuneB_q <= RST_SENSITIVITY_TUNE_B;
      tuneC_q <= RST_SENSITIVITY_TUNE_C;
    end else if (wrLow) begin
      // writes are accepted; leaving these alone is the host's duty
      if (wrIdx == IDX_SYNTH_TEST) synthTest_q <= wData_q[7:0];
      if (wrIdx == IDX_PRODUCTION_TEST) prodTest_q <= wData_q[7:0];
      if (wrIdx == IDX_GAIN_CONTROL_TEST) gainTest_q <= wData_q[7:0];
      if (wrIdx == IDX_SENSITIVITY_TUNE_A) tuneA_q <= wData_q[7:0];
      if (wrIdx == IDX_SENSITIVITY_TUNE_B) tuneB_q <= wData_q[7:0];
      if (wrIdx == IDX_SENSITIVITY_TUNE_C) tuneC_q <= wData_q[7:0];
    end
  end

  // control outputs steered by software
  assign tempSensorEnable = (prodTest_q == TEMP_SENSOR_ENABLE_CODE)
                            && (modemStatus.radioState == STATE_IDLE);
  assign vcoSelectStageEnable = tuneC_q[VCO_SELECT_STAGE_BIT];
  assign synthCalControl = synthCal_q;
  assign rcOscConfigHi = rcHi_q;
  assign rcOscConfigLo = rcLo_q;
  assign synthTest = synthTest_q;
  assign gainControlTest = gainTest_q;
  assign sensitivityTuneA = tuneA_q;
  assign sensitivityTuneB = tuneB_q;

  // ------------------------------------------------------------------
  // status capture from the modem
  // ------------------------------------------------------------------
  logic [7:0] freq_offset_estimate_q;
  logic crcMatch_q;
  logic [6:0] lqi_q;
  logic [7:0] signal_strength_q;
  logic [4:0] radioState_q;

  // offset estimate only tracks frequency-shift modulations
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freq_offset_estimate_q <= 8'h00;
    end else if (modemStatus.onOffKeying) begin
      freq_offset_estimate_q <= 8'h00;
    end else begin
      freq_offset_estimate_q <= modemStatus.freqOffset;
    end
  end

  // crc result set wins over a receive restart in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crcMatch_q <= 1'b0;
    end else if (modemStatus.crcDone) begin
      crcMatch_q <= modemStatus.crcMatch && legacyCompatEnable;
    end else if (rxEnter) begin
      crcMatch_q <= 1'b0;
    end
  end

  // quality value from the 64 symbols past sync, computed upstream
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lqi_q <= 7'h00;
      signal_strength_q <= 8'h00;
      radioState_q <= STATE_SLEEP;
    end else begin
      if (modemStatus.lqiValid) lqi_q <= modemStatus.lqiValue;
      if (modemStatus.rssiValid) signal_strength_q <= modemStatus.rssiValue;
      radioState_q <= modemStatus.radioState;
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic [7:0] rdIdx;
  logic [7:0] rdWord;
  logic rdHit;

  // one read in flight: arready drops while data waits
  assign s_axi_arready = !rValid_q;
  assign rdIdx = statusBase(wordIndex(s_axi_araddr));

  // read mux; unmapped reads give zero with an error
  always_comb begin
    rdHit = 1'b1;
    rdWord = 8'h00;
    case (rdIdx)
      IDX_SYNTH_CAL_CONTROL: rdWord = {1'b0, synthCal_q};
      IDX_RC_OSC_CONFIG_HI: rdWord = {1'b0, rcHi_q};
      IDX_RC_OSC_CONFIG_LO: rdWord = {1'b0, rcLo_q};
      IDX_SYNTH_TEST: rdWord = synthTest_q;
      IDX_PRODUCTION_TEST: rdWord = prodTest_q;
      IDX_GAIN_CONTROL_TEST: rdWord = gainTest_q;
      IDX_SENSITIVITY_TUNE_A: rdWord = tuneA_q;
      IDX_SENSITIVITY_TUNE_B: rdWord = tuneB_q;
      IDX_SENSITIVITY_TUNE_C: rdWord = tuneC_q;
      IDX_CHIP_PART_ID: rdWord = PART_ID;
      IDX_CHIP_REVISION_ID: rdWord = REVISION_ID;
      IDX_FREQ_OFFSET_ESTIMATE: rdWord = freq_offset_estimate_q;
      IDX_LINK_QUALITY: rdWord = {crcMatch_q, lqi_q};
      IDX_SIGNAL_STRENGTH: rdWord = signal_strength_q;
      IDX_RADIO_STATE_CODE: rdWord = {3'b000, radioState_q};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rData_q <= {24'h00_0000, rdWord};
      rResp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

endmodule : rts_register_bank

// ===== rts_register_bank_props.sv
// assertion checker for the radio test and status register bank
`timescale 1ns/10ps
module rts_register_bank_props
  import rts_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input rts_modem_status_t modemStatus,
  input wire logic tempSensorEnable,
  input wire logic [7:0] synthTest,
  input wire logic [7:0] sensitivityTuneA
);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_temp_idle: assert property (tempSensorEnable |-> modemStatus.radioState == STATE_IDLE)
    else $error("temperature sensor on outside idle");
  chk_sleep_revert: assert property (modemStatus.radioState == STATE_SLEEP |=>
    synthTest == RST_SYNTH_TEST && sensitivityTuneA == RST_SENSITIVITY_TUNE_A)
    else $error("test group kept contents through sleep");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule : rts_register_bank_props

bind rts_register_bank rts_register_bank_props chk (.clk(clk), .resetn(resetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .modemStatus(modemStatus), .tempSensorEnable(tempSensorEnable),
  .synthTest(synthTest), .sensitivityTuneA(sensitivityTuneA));

// ===== rts_host_model.sv
// host model: axi4-lite master that reaches the register bank
`timescale 1ns/10ps
module rts_host_model (
  input wire logic clk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // a stuck handshake ends the run through the bench's report
  task automatic hang();
    rts_register_bank_tb_top.mismatches++;
    rts_register_bank_tb_top.finish_test();
  endtask : hang
  // never aimed at synth_test or gain_control_test by the bench
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    bit pa;
    bit pw;
    bit ta;
    bit tw;
    int n;
    pa = 1;
    pw = 1;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b110;
    // ready sampled at the falling edge: inputs only move at rising edges
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      if (++n > 50) hang();
    end
    // bready two edges late so a waiting response is seen held
    repeat (2) @(posedge clk);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 100) hang();
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    bit ta;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b10;
    do begin
      @(negedge clk);
      ta = s_axi_arready;
      @(posedge clk);
      if (++n > 50) hang();
    end while (!ta);
    s_axi_arvalid <= 1'b0;
    // rready one edge late so waiting read data is seen held
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 100) hang();
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rts_host_model

// ===== rts_register_bank_tb_top.sv
// self-checking testbench for the radio test and status register bank
`timescale 1ns/10ps
module rts_register_bank_tb_top;
  import rts_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] wrsp;
    logic [1:0] rrsp;
  } rts_row_t;
  localparam logic [7:0] PART = 8'h6c; // arbitrary identity value
  localparam logic [7:0] REV = 8'h02; // arbitrary identity value
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  rts_modem_status_t ms = '{radioState: STATE_IDLE, default: '0};
  logic legacy = 1'b0;
  logic rxEnter = 1'b0;
  logic tempOn, wakeup_osc_on;
  logic [6:0] calOut, rcHiOut, rcLoOut;
  logic [7:0] fsOut, agcOut, tuneAOut, tuneBOut;
  int mismatches = 0;
  int n_checks = 0;
  rts_row_t rows[9] = '{
    '{8'h26, 8'hff, 8'h7f, RESP_OKAY, RESP_OKAY}, '{8'h27, 8'h80, 8'h00, RESP_OKAY, RESP_OKAY},
    '{8'h28, 8'h55, 8'h55, RESP_OKAY, RESP_OKAY}, '{8'h2a, 8'hbf, 8'hbf, RESP_OKAY, RESP_OKAY},
    '{8'h2c, 8'h81, 8'h81, RESP_OKAY, RESP_OKAY}, '{8'h2d, 8'h35, 8'h35, RESP_OKAY, RESP_OKAY},
    '{8'h2e, 8'h09, 8'h09, RESP_OKAY, RESP_OKAY}, '{8'h30, 8'h11, PART, RESP_SLVERR, RESP_OKAY},
    '{8'h2f, 8'h22, 8'h00, RESP_SLVERR, RESP_SLVERR}};
  logic [7:0] rstVal[9] = '{8'h0d, 8'h41, 8'h00, 8'h59, 8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b};

  // ------------------------------------------------------------------
  // clock, design and host
  // ------------------------------------------------------------------
  // 200 MHz
  always #2.5 clk = ~clk;
  rts_register_bank #(.PART_ID(PART), .REVISION_ID(REV)) uut (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .modemStatus(ms), .legacyCompatEnable(legacy), .rxEnter(rxEnter),
    .tempSensorEnable(tempOn), .vcoSelectStageEnable(wakeup_osc_on), .synthCalControl(calOut),
    .rcOscConfigHi(rcHiOut), .rcOscConfigLo(rcLoOut), .synthTest(fsOut),
    .gainControlTest(agcOut), .sensitivityTuneA(tuneAOut), .sensitivityTuneB(tuneBOut));
  rts_host_model host (.clk(clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] rr;
    host.rd(idx, d, rr);
    chk(d, {24'h0, exp});
    chk(32'(rr), 32'(er));
  endtask : rdchk
  // reset held eight cycles, first request four edges after release
  task automatic do_reset();
    @(posedge clk) resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // one-cycle receiver result strobes
  task automatic strobe();
    @(posedge clk) {ms.crcDone, ms.lqiValid, ms.rssiValid} <= 3'b111;
    @(posedge clk) {ms.crcDone, ms.lqiValid, ms.rssiValid} <= 3'b000;
  endtask : strobe
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 9; i++) begin
      host.wr(rows[i].idx, rows[i].wd, r);
      chk(32'(r), 32'(rows[i].wrsp));
      rdchk(rows[i].idx, rows[i].rd, rows[i].rrsp);
    end
    chk(32'(wakeup_osc_on), 32'h0);
    chk(32'(tempOn), 32'h1);
    chk({calOut, rcHiOut, rcLoOut, 11'h0}, {7'h7f, 7'h00, 7'h55, 11'h0});
    chk({fsOut, agcOut, tuneAOut, tuneBOut}, 32'h593f_8135);
    host.wr(IDX_PRODUCTION_TEST, RST_PRODUCTION_TEST, r);
    chk(32'(tempOn), 32'h0);
    // sleep drops the test group but not the configuration registers
    @(posedge clk) ms.radioState <= STATE_SLEEP;
    repeat (2) @(posedge clk);
    ms.radioState <= STATE_IDLE;
    rdchk(IDX_SENSITIVITY_TUNE_A, RST_SENSITIVITY_TUNE_A, RESP_OKAY);
    rdchk(IDX_RC_OSC_CONFIG_LO, 8'h55, RESP_OKAY);
    @(posedge clk) ms.freqOffset <= 8'hf3;
    repeat (2) @(posedge clk);
    rdchk(IDX_FREQ_OFFSET_ESTIMATE, 8'hf3, RESP_OKAY);
    ms.onOffKeying <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk(8'hf2, 8'h00, RESP_OKAY);
    {ms.crcMatch, ms.lqiValue, ms.rssiValue, legacy} <= {1'b1, 7'h5a, 8'h9c, 1'b1};
    strobe();
    rdchk(IDX_LINK_QUALITY, 8'hda, RESP_OKAY);
    rdchk(8'hf4, 8'h9c, RESP_OKAY);
    @(posedge clk) rxEnter <= 1'b1;
    @(posedge clk) rxEnter <= 1'b0;
    rdchk(8'hf3, 8'h5a, RESP_OKAY);
    legacy <= 1'b0;
    strobe();
    rdchk(IDX_LINK_QUALITY, 8'h5a, RESP_OKAY);
    host.wr(8'hf4, 8'h00, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rdchk(IDX_SIGNAL_STRENGTH, 8'h9c, RESP_OKAY);
    rdchk(8'hf1, REV, RESP_OKAY);
    // every state code read back through the status alias
    for (int s = 0; s < 23; s++) begin
      @(posedge clk) ms.radioState <= 5'(s);
      repeat (2) @(posedge clk);
      rdchk(8'hf5, 8'(s), RESP_OKAY);
    end
    ms.radioState <= STATE_IDLE;
    do_reset();
    for (int i = 0; i < 9; i++) begin
      rdchk(8'(8'h26 + i), rstVal[i], RESP_OKAY);
    end
    chk(32'(wakeup_osc_on), 32'h1);
    chk({calOut, rcHiOut, rcLoOut, 11'h0}, {7'h0d, 7'h41, 7'h00, 11'h0});
    finish_test();
  end
endmodule : rts_register_bank_tb_top
